// file: pkg/flash_id_defines.svh
// constants for the serial flash identification / sleep / pause link
// assumes inclusion by bare name from package and design files
`ifndef FLASH_ID_DEFINES_SVH
`define FLASH_ID_DEFINES_SVH
`define OP_LEGACY_ID      8'h90
`define OP_SLEEP          8'hb9
`define OP_WAKE           8'hab
`define DUMMY_BYTES       2'h3
`define BITS_PER_BYTE     4'h8
// identity bytes below are arbitrary
`define MFR_CODE_DEFAULT  8'h5a
`define DEV_CODE_DEFAULT  8'ha5
`define SLEEP_ENTRY_NS    3000
`define SLEEP_EXIT_NS     8000
`define WAKE_HOLD_OFF_NS  8000
`define CLK_PERIOD_NS     40
`define SCK_HALF_DIV      6
`endif

// file: pkg/flash_id_pkg.sv
// types shared by both ends of the flash serial link
// assumes the defines header is on the include path
package flash_id_pkg;
  `include "flash_id_defines.svh"
  typedef enum logic [1:0]
  {
    PWR_STANDBY = 2'b00,
    PWR_ENTER   = 2'b01,
    PWR_SLEEP   = 2'b10,
    PWR_EXIT    = 2'b11
  } pwr_e;
  typedef enum logic [2:0]
  {
    CMD_OPCODE = 3'b000,
    CMD_DUMMY  = 3'b001,
    CMD_OUT    = 3'b010,
    CMD_IGNORE = 3'b011,
    CMD_DONE   = 3'b100
  } cmd_e;
  typedef enum logic [2:0]
  {
    HST_IDLE  = 3'b000,
    HST_LOW   = 3'b001,
    HST_HIGH  = 3'b010,
    HST_GAP   = 3'b011,
    HST_WAIT  = 3'b100
  } hst_e;
  function automatic logic [15:0] ns_to_cycles_max(input int ns);
    int c;
    c = ns / `CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[15:0];
  endfunction
  function automatic logic [15:0] ns_to_cycles_min(input int ns);
    int c;
    c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[15:0];
  endfunction
endpackage

// file: pkg/flash_link_if.sv
// serial flash bus between host and flash; resolves shared pins
// assumes the flash end uses active-low output enables
interface flash_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe_n;
  logic so;
  logic pause_n;
  logic pause_o;
  logic pause_oe_n;
  logic pause_pin;
  logic wp_n;
  assign so = so_oe_n ? 1'b1 : so_o;
  assign pause_pin = pause_oe_n ? pause_n : pause_o;
  modport host
  (
    output cs_n,
    output sck,
    output si,
    output pause_n,
    output wp_n,
    input  so
  );
  modport flash
  (
    input  cs_n,
    input  sck,
    input  si,
    input  pause_pin,
    input  wp_n,
    output so_o,
    output so_oe_n,
    output pause_o,
    output pause_oe_n
  );
endinterface

// file: rtl/flash_id_device.sv
// flash end: opcode decoder for legacy id, sleep entry/exit, wake-id, pause
// assumes link pins arrive asynchronously and are sampled on clk
`include "flash_id_defines.svh"
// Summary of operation
// RQ1: opcode 90h, three dummies, then manufacturer, device
// RQ2: legacy id bytes alternate while clocking continues
// RQ3: chip select release ends read, floats output
// RQ4: standby whenever deselected and nothing self-timed runs
// RQ5: B9h then release enters sleep within limit
// RQ6: short or unaligned sleep request stays standby
// RQ7: asleep, everything except ABh is ignored
// RQ8: sleep request ignored while program/erase busy
// RQ9: after reset device is standby, not asleep
// RQ10: ABh then release wakes within exit time
// RQ11: short or unaligned wake leaves device asleep
// RQ12: ABh plus three dummies outputs device code
// RQ13: wake-id device code repeats from bit seven
// RQ14: host waits hold-off after wake-id from sleep
// RQ15: pause never stops a self-timed operation
// RQ16: quad enable removes pause pin control role
// RQ17: pause starts on clock low while selected
// RQ18: paused: output floats, input and clock ignored
// RQ19: pause ends at clock low after release
// RQ20: deselect during pause aborts, clears write latch
// RQ21: id bytes msb first, change on falling edge
// RQ22: quad disabled, pause and protect are inputs
module flash_id_device #(
  parameter logic [7:0] MFR_CODE = `MFR_CODE_DEFAULT,
  parameter logic [7:0] DEV_CODE = `DEV_CODE_DEFAULT
)(
  input  wire logic clk,
  input  wire logic rst,
  flash_link_if.flash link,
  input  wire logic quad_io_enable_bit,
  input  wire logic self_timed_busy,
  input  wire logic write_latch_set,
  output logic      write_latch_flag,
  output logic      asleep,
  output logic      paused,
  output logic      wp_level
);
  import flash_id_pkg::*;
  localparam logic [15:0] ENTRY_CYC = ns_to_cycles_max(`SLEEP_ENTRY_NS);
  localparam logic [15:0] EXIT_CYC  = ns_to_cycles_max(`SLEEP_EXIT_NS);
  initial
  begin
    if (ENTRY_CYC == 16'h0 || EXIT_CYC == 16'h0)
    begin
      $error("timing counts must be nonzero");
    end
  end

  // three-stage samplers; stage 1 feeds only stage 2; bit 4 carries write protect
  logic [4:0] s1, s2, s3;
  logic [4:0] next_s1, next_s2, next_s3;
  logic cs_n_q, sck_q, si_q, pin_q, sck_prev;
  logic next_cs_n_q, next_sck_q, next_si_q, next_pin_q, next_sck_prev;
  always_comb
  begin
    next_s1 = {link.wp_n, link.cs_n, link.sck, link.si, link.pause_pin};
    next_s2 = s1;
    next_s3 = s2;
    next_cs_n_q = (s2[3] == s3[3]) ? s3[3] : cs_n_q;
    next_sck_q  = (s2[2] == s3[2]) ? s3[2] : sck_q;
    next_si_q   = (s2[1] == s3[1]) ? s3[1] : si_q;
    next_pin_q  = (s2[0] == s3[0]) ? s3[0] : pin_q;
    next_sck_prev = sck_q;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // idle pin levels, so no false clock edge follows reset
      s1 <= 5'h19;
      s2 <= 5'h19;
      s3 <= 5'h19;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      pin_q <= 1'b1;
      sck_prev <= 1'b0;
    end
    else
    begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      cs_n_q <= next_cs_n_q;
      sck_q <= next_sck_q;
      si_q <= next_si_q;
      pin_q <= next_pin_q;
      sck_prev <= next_sck_prev;
    end
  end

  logic sck_rise, sck_fall, cs_rel;
  logic cs_prev, next_cs_prev;
  assign sck_rise = sck_q & ~sck_prev & ~paused;   // [RQ18]
  assign sck_fall = ~sck_q & sck_prev & ~paused;   // [RQ18]
  assign cs_rel = cs_n_q & ~cs_prev;
  assign next_cs_prev = cs_n_q;

  // command state
  cmd_e        cmd, next_cmd;
  pwr_e        pwr, next_pwr;
  logic [7:0]  op, next_op;
  logic [7:0]  shreg, next_shreg;
  logic [2:0]  bitc, next_bitc;
  logic        aligned, next_aligned;
  logic [1:0]  dummies, next_dummies;
  logic        which, next_which;
  logic [15:0] tmr, next_tmr;
  logic        so_o, next_so_o, so_oe_n, next_so_oe_n;
  logic        next_paused, next_wl, next_asleep, next_wp;
  logic        sleep_ok, next_sleep_ok;
  logic        wake_ok, next_wake_ok;

  always_comb
  begin
    next_cmd = cmd;
    next_pwr = pwr;
    next_op = op;
    next_shreg = shreg;
    next_bitc = bitc;
    next_aligned = aligned;
    next_dummies = dummies;
    next_which = which;
    next_tmr = tmr;
    next_so_o = so_o;
    next_so_oe_n = so_oe_n;
    next_paused = paused;
    next_wl = write_latch_flag | write_latch_set;
    next_sleep_ok = sleep_ok;
    next_wake_ok = wake_ok;
    next_wp = (s2[4] == s3[4]) ? s3[4] : wp_level;              // [RQ18] [RQ22]
    // pause control only when quad disabled and selected          [RQ16] [RQ22]
    if (quad_io_enable_bit || cs_n_q)
    begin
      next_paused = 1'b0;
    end
    else if (!sck_q)
    begin
      next_paused = ~pin_q;                                      // [RQ17] [RQ19]
    end
    if (cs_n_q && ~pin_q && !quad_io_enable_bit && (paused || cmd != CMD_DONE) && !cs_prev)
    begin
      next_wl = 1'b0;                                            // [RQ20]
    end
    if (cs_rel)
    begin
      next_so_oe_n = 1'b1;                                       // [RQ3]
      next_cmd = CMD_DONE;
      if (!(paused && !quad_io_enable_bit))
      begin
        if (pwr == PWR_STANDBY && sleep_ok && aligned && !self_timed_busy)
        begin
          next_pwr = PWR_ENTER;                                  // [RQ5] [RQ6] [RQ8]
          next_tmr = ENTRY_CYC;
        end
        else if (pwr == PWR_SLEEP && wake_ok && aligned)
        begin
          next_pwr = PWR_EXIT;                                   // [RQ10] [RQ11]
          next_tmr = EXIT_CYC;
        end
      end
    end
    else if (!cs_n_q && cs_prev)
    begin
      next_cmd = CMD_OPCODE;
      next_bitc = 3'h0;
      next_aligned = 1'b1;
      next_sleep_ok = 1'b0;
      next_wake_ok = 1'b0;
    end
    else if (!cs_n_q && sck_rise)
    begin
      next_shreg = {shreg[6:0], si_q};
      next_bitc = bitc + 3'h1;
      next_aligned = (bitc == 3'h7);
      if (cmd == CMD_OPCODE && bitc == 3'h7)
      begin
        next_op = {shreg[6:0], si_q};
        next_dummies = 2'h0;
        next_which = 1'b0;
        if (pwr == PWR_SLEEP)
        begin
          // asleep: only the wake opcode is recognised          [RQ7]
          next_wake_ok = ({shreg[6:0], si_q} == `OP_WAKE);
          next_cmd = next_wake_ok ? CMD_DUMMY : CMD_IGNORE;
        end
        else
        begin
          next_sleep_ok = ({shreg[6:0], si_q} == `OP_SLEEP);    // [RQ5]
          next_wake_ok = 1'b0;
          next_cmd = ({shreg[6:0], si_q} == `OP_LEGACY_ID || {shreg[6:0], si_q} == `OP_WAKE)
                     ? CMD_DUMMY : CMD_IGNORE;
        end
      end
      else if (cmd == CMD_DUMMY && bitc == 3'h7)
      begin
        next_dummies = dummies + 2'h1;
        if (dummies + 2'h1 == `DUMMY_BYTES)
        begin
          next_cmd = CMD_OUT;                                    // [RQ1] [RQ12]
          next_shreg = (op == `OP_LEGACY_ID) ? MFR_CODE : DEV_CODE;
        end
      end
      else if (cmd == CMD_OUT && bitc == 3'h7)
      begin
        next_which = ~which;
        if (op == `OP_LEGACY_ID)
        begin
          next_shreg = which ? MFR_CODE : DEV_CODE;              // [RQ2]
        end
        else
        begin
          next_shreg = DEV_CODE;                                 // [RQ13]
        end
      end
      else if (cmd == CMD_OUT)
      begin
        next_shreg = {shreg[6:0], 1'b0};
      end
    end
    else if (!cs_n_q && sck_fall && cmd == CMD_OUT)
    begin
      next_so_o = shreg[7];                                      // [RQ21] [RQ12]
      next_so_oe_n = 1'b0;
    end
    if (paused)
    begin
      next_so_oe_n = 1'b1;                                       // [RQ18]
    end
    // leaving pause mid-read drives the held bit again
    if (paused && !next_paused && cmd == CMD_OUT && !cs_n_q)
    begin
      next_so_oe_n = 1'b0;                                       // [RQ19]
    end
    // sleep entry / exit timers run regardless of pause           [RQ15]
    if (pwr == PWR_ENTER || pwr == PWR_EXIT)
    begin
      if (tmr <= 16'h1)
      begin
        next_pwr = (pwr == PWR_ENTER) ? PWR_SLEEP : PWR_STANDBY; // [RQ4]
      end
      else
      begin
        next_tmr = tmr - 16'h1;
      end
    end
    next_asleep = (next_pwr == PWR_SLEEP);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cs_prev <= 1'b1;
      cmd <= CMD_DONE;
      pwr <= PWR_STANDBY;                                        // [RQ9]
      op <= 8'h0;
      shreg <= 8'h0;
      bitc <= 3'h0;
      aligned <= 1'b1;
      dummies <= 2'h0;
      which <= 1'b0;
      tmr <= 16'h0;
      so_o <= 1'b0;
      so_oe_n <= 1'b1;
      paused <= 1'b0;
      write_latch_flag <= 1'b0;
      asleep <= 1'b0;
      wp_level <= 1'b1;
      sleep_ok <= 1'b0;
      wake_ok <= 1'b0;
    end
    else
    begin
      cs_prev <= next_cs_prev;
      cmd <= next_cmd;
      pwr <= next_pwr;
      op <= next_op;
      shreg <= next_shreg;
      bitc <= next_bitc;
      aligned <= next_aligned;
      dummies <= next_dummies;
      which <= next_which;
      tmr <= next_tmr;
      so_o <= next_so_o;
      so_oe_n <= next_so_oe_n;
      paused <= next_paused;
      write_latch_flag <= next_wl;
      asleep <= next_asleep;
      wp_level <= next_wp;
      sleep_ok <= next_sleep_ok;
      wake_ok <= next_wake_ok;
    end
  end

  assign link.so_o = so_o;
  assign link.so_oe_n = so_oe_n;
  assign link.pause_o = 1'b1;
  assign link.pause_oe_n = 1'b1;                                 // [RQ22]
endmodule

// file: rtl/flash_id_host.sv
// host end: issues one serial command, returns captured id byte
// assumes user holds start until busy rises; sck made by divider of clk
`include "flash_id_defines.svh"
module flash_id_host #(
  parameter int DIV = `SCK_HALF_DIV
)(
  input  wire logic       clk,
  input  wire logic       rst,
  flash_link_if.host      link,
  input  wire logic       start,
  input  wire logic [7:0] opcode,
  input  wire logic [2:0] dummy_count,
  input  wire logic [3:0] read_count,
  input  wire logic       woke_from_sleep,
  output logic            busy,
  output logic [7:0]      rx_byte,
  output logic            rx_valid
);
  import flash_id_pkg::*;
  localparam logic [15:0] HOLD_CYC = ns_to_cycles_min(`WAKE_HOLD_OFF_NS);
  initial
  begin
    if (DIV < 1 || DIV > 255)
    begin
      $error("divider out of range");
    end
  end
  hst_e        st, next_st;
  logic [7:0]  div, next_div;
  logic [7:0]  tx, next_tx;
  logic [7:0]  rx, next_rx;
  logic [2:0]  bitc, next_bitc;
  logic [4:0]  bytes, next_bytes;
  logic [4:0]  total, next_total;
  logic [15:0] wait_c, next_wait_c;
  logic [2:0]  so_s, next_so_s;
  logic        so_q, next_so_q;
  logic        cs_n, sck, si, next_cs_n, next_sck, next_si;
  logic        next_busy, next_valid;
  logic [7:0]  next_rx_byte;
  logic        tick;
  assign tick = (div == 8'(DIV - 1));
  always_comb
  begin
    next_st = st;
    next_div = tick ? 8'h0 : div + 8'h1;
    next_tx = tx;
    next_rx = rx;
    next_bitc = bitc;
    next_bytes = bytes;
    next_total = total;
    next_wait_c = wait_c;
    next_so_s = {so_s[1:0], link.so};
    next_so_q = (so_s[1] == so_s[2]) ? so_s[2] : so_q;
    next_cs_n = cs_n;
    next_sck = sck;
    next_si = si;
    next_busy = busy;
    next_valid = 1'b0;
    next_rx_byte = rx_byte;
    case (st)
      HST_IDLE:
      begin
        if (start && tick)
        begin
          next_st = HST_LOW;
          next_cs_n = 1'b0;
          next_busy = 1'b1;
          next_tx = opcode;
          next_si = opcode[7];
          next_bitc = 3'h0;
          next_bytes = 5'h0;
          next_total = 5'(1 + dummy_count + read_count);
        end
      end
      HST_LOW:
      begin
        if (tick)
        begin
          next_sck = 1'b1;
          next_st = HST_HIGH;
        end
      end
      HST_HIGH:
      begin
        if (tick)
        begin
          next_sck = 1'b0;
          // sampled at the end of the high phase: the flash answers clocks after each fall
          next_rx = {rx[6:0], so_q};
          next_bitc = bitc + 3'h1;
          next_tx = {tx[6:0], 1'b0};
          next_si = tx[6];
          next_st = HST_LOW;
          if (bitc == 3'h7)
          begin
            next_bytes = bytes + 5'h1;
            next_tx = 8'h0;
            next_si = 1'b0;
            if (bytes > {2'h0, dummy_count})
            begin
              next_rx_byte = {rx[6:0], so_q};
              next_valid = 1'b1;
            end
            if (bytes + 5'h1 == total)
            begin
              next_st = HST_GAP;
            end
          end
        end
      end
      HST_GAP:
      begin
        if (tick)
        begin
          next_cs_n = 1'b1;
          next_wait_c = woke_from_sleep && opcode == `OP_WAKE && dummy_count != 3'h0
                        ? HOLD_CYC : 16'h1;                      // [RQ14]
          next_st = HST_WAIT;
        end
      end
      HST_WAIT:
      begin
        if (wait_c <= 16'h1)
        begin
          next_st = HST_IDLE;
          next_busy = 1'b0;
        end
        else
        begin
          next_wait_c = wait_c - 16'h1;
        end
      end
      default:
      begin
        next_st = HST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= HST_IDLE;
      div <= 8'h0;
      tx <= 8'h0;
      rx <= 8'h0;
      bitc <= 3'h0;
      bytes <= 5'h0;
      total <= 5'h0;
      wait_c <= 16'h0;
      so_s <= 3'h7;
      so_q <= 1'b1;
      cs_n <= 1'b1;
      sck <= 1'b0;
      si <= 1'b0;
      busy <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h0;
    end
    else
    begin
      st <= next_st;
      div <= next_div;
      tx <= next_tx;
      rx <= next_rx;
      bitc <= next_bitc;
      bytes <= next_bytes;
      total <= next_total;
      wait_c <= next_wait_c;
      so_s <= next_so_s;
      so_q <= next_so_q;
      cs_n <= next_cs_n;
      sck <= next_sck;
      si <= next_si;
      busy <= next_busy;
      rx_valid <= next_valid;
      rx_byte <= next_rx_byte;
    end
  end
  assign link.cs_n = cs_n;
  assign link.sck = sck;
  assign link.si = si;
  assign link.pause_n = 1'b1;
  assign link.wp_n = 1'b1;
endmodule

// file: test/flash_link_chk.sv
// checker for the serial link between the host end and the flash end
// assumes clk samples every link pin; instantiated in tb_top beside the interface
module flash_link_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe_n,
  input wire logic pause_oe_n
);
  logic       sck_q;
  logic       cs_q;
  logic [7:0] edge_cnt;
  logic [7:0] next_edge_cnt;
  logic [3:0] fall_age;
  logic [3:0] next_fall_age;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // rising clock edges seen in the current frame, and cycles since the last falling edge
  always_comb
  begin
    next_edge_cnt = edge_cnt;
    if (cs_q && !cs_n)
      next_edge_cnt = 8'h00;
    else if (!cs_n && sck && !sck_q && edge_cnt != 8'hff)
      next_edge_cnt = edge_cnt + 8'h01;
    next_fall_age = (fall_age == 4'hf) ? fall_age : fall_age + 4'h1;
    if (sck_q && !sck)
      next_fall_age = 4'h0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      edge_cnt <= 8'h00;
      fall_age <= 4'hf;
    end
    else
    begin
      sck_q <= sck;
      cs_q <= cs_n;
      edge_cnt <= next_edge_cnt;
      fall_age <= next_fall_age;
    end
  end

  sequence frame_end;
    $rose(cs_n);
  endsequence
  sequence float_soon;
    ##[1:8] so_oe_n;
  endsequence

  so_release_a: assert property (frame_end |-> float_soon) else $error("output driven after deselect");
  idle_float_a: assert property (cs_n [*8] |-> so_oe_n) else $error("output driven while deselected");
  drive_start_a: assert property ($fell(so_oe_n) |-> !cs_n && edge_cnt >= 8'h20) else $error("early drive");
  out_edge_a: assert property (!so_oe_n && !$past(so_oe_n) && $changed(so_o) |-> fall_age <= 4'h6)
    else $error("output changed away from a falling edge");
  pause_role_a: assert property (pause_oe_n) else $error("pause pin driven by flash");
  sck_idle_a: assert property (cs_n |-> !sck) else $error("link clock moves outside a frame");
  si_hold_a: assert property (sck && $past(sck) |-> $stable(si)) else $error("input changed while clock high");
  byte_frame_a: assert property (frame_end |-> edge_cnt[2:0] == 3'h0) else $error("frame not whole bytes");
endmodule

// file: test/tb_top.sv
// bench: host and flash joined on one link, a second flash driven bit by bit by the bench
// assumes package and interface compile first; clk 25 MHz, bench link clock 320 ns
`include "flash_id_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_id_pkg::*;
  localparam int         ENTRY_LIM = `SLEEP_ENTRY_NS / `CLK_PERIOD_NS + 10;
  localparam int         EXIT_LIM  = `SLEEP_EXIT_NS / `CLK_PERIOD_NS + 10;
  localparam logic [7:0] MFR       = `MFR_CODE_DEFAULT;
  localparam logic [7:0] DEV       = `DEV_CODE_DEFAULT;
  localparam logic [7:0] SEQ_OP [6] = '{8'hb9, 8'hb9, 8'hb9, 8'hab, 8'hab, 8'hab};
  localparam int         SEQ_N [6]  = '{4, 11, 16, 5, 12, 8};
  localparam logic       SEQ_X [6]  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  typedef struct packed
  {
    logic [7:0] op;
    logic [2:0] dum;
    logic [3:0] rd;
    logic       woke;
    logic       bsy;
    logic [7:0] even;
    logic [7:0] odd;
    logic       slp;
  } row_s;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         start = 1'b0;
  logic [7:0]   opcode = 8'h00;
  logic [2:0]   dummy_count = 3'h0;
  logic [3:0]   read_count = 4'h0;
  logic         woke_from_sleep = 1'b0;
  logic         self_timed_busy = 1'b0;
  logic         quad_b = 1'b0;
  logic         set_b = 1'b0;
  logic         busy;
  logic [7:0]   rx_byte;
  logic         rx_valid;
  logic         asleep;
  logic         asleep_b;
  logic         paused_b;
  logic         flag_b;
  logic         wp_b;
  logic [7:0]   rx_b = 8'h00;
  int           n_checks = 0;
  int           n_mismatch = 0;
  row_s         rows [8];
  flash_link_if lk();
  flash_link_if lk_b();

  always #20 clk = ~clk;

  flash_id_host flash_id_host_i (.clk(clk), .rst(rst), .link(lk), .start(start), .opcode(opcode),
    .dummy_count(dummy_count), .read_count(read_count), .woke_from_sleep(woke_from_sleep), .busy(busy),
    .rx_byte(rx_byte), .rx_valid(rx_valid));
  flash_id_device flash_id_device_i (.clk(clk), .rst(rst), .link(lk), .quad_io_enable_bit(1'b0),
    .self_timed_busy(self_timed_busy), .write_latch_set(1'b0), .write_latch_flag(), .asleep(asleep),
    .paused(), .wp_level());
  flash_id_device flash_id_device_b_i (.clk(clk), .rst(rst), .link(lk_b), .quad_io_enable_bit(quad_b),
    .self_timed_busy(1'b0), .write_latch_set(set_b), .write_latch_flag(flag_b), .asleep(asleep_b),
    .paused(paused_b), .wp_level(wp_b));
  flash_link_chk flash_link_chk_i (.clk(clk), .rst(rst), .cs_n(lk.cs_n), .sck(lk.sck), .si(lk.si),
    .so_o(lk.so_o), .so_oe_n(lk.so_oe_n), .pause_oe_n(lk.pause_oe_n));

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // bench link: data set after the falling edge, output sampled mid high phase
  task automatic shift_b(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      lk_b.si <= b[i];
      half();
      lk_b.sck <= 1'b1;
      repeat (2) @(posedge clk);
      rx_b = {rx_b[6:0], lk_b.so};
      repeat (2) @(posedge clk);
      lk_b.sck <= 1'b0;
    end
  endtask

  task automatic frame_b(input logic [7:0] op, input int n);
    lk_b.cs_n <= 1'b0;
    shift_b(op, n > 8 ? 8 : n);
    if (n > 8)
      shift_b(8'h00, n - 8);
    half();
    lk_b.cs_n <= 1'b1;
    repeat (EXIT_LIM) @(posedge clk);
  endtask

  task automatic host_cmd(input row_s r);
    int k;
    int t;
    int tm;
    k = 0;
    t = 0;
    tm = -1;
    opcode <= r.op;
    dummy_count <= r.dum;
    read_count <= r.rd;
    woke_from_sleep <= r.woke;
    self_timed_busy <= r.bsy;
    start <= 1'b1;
    while (busy !== 1'b1 && t < 100)
    begin
      @(posedge clk);
      t++;
    end
    start <= 1'b0;
    while (busy === 1'b1 && t < 4000)
    begin
      @(posedge clk);
      t++;
      if (rx_valid === 1'b1)
      begin
        chk8("rx_byte", k[0] ? r.odd : r.even, rx_byte);
        k++;
      end
    end
    chk8("byte count", {4'h0, r.rd}, k[7:0]);
    for (t = 0; t < EXIT_LIM; t++)
    begin
      @(posedge clk);
      if (tm < 0 && asleep === r.slp)
        tm = t;
    end
    chk1("asleep", r.slp, asleep);
    chk1("sleep timing", 1'b1, tm >= 0 && tm <= (r.slp ? ENTRY_LIM : EXIT_LIM));
  endtask

  initial
  begin
    lk_b.cs_n = 1'b1;
    lk_b.sck = 1'b0;
    lk_b.si = 1'b0;
    lk_b.pause_n = 1'b1;
    lk_b.wp_n = 1'b1;
    rows[0] = '{8'h90, 3'h3, 4'h4, 1'b0, 1'b0, MFR, DEV, 1'b0};
    rows[1] = '{8'hb9, 3'h0, 4'h0, 1'b0, 1'b1, MFR, DEV, 1'b0};
    rows[2] = '{8'hb9, 3'h0, 4'h1, 1'b0, 1'b0, 8'hff, 8'hff, 1'b1};
    rows[3] = '{8'h90, 3'h3, 4'h2, 1'b0, 1'b0, 8'hff, 8'hff, 1'b1};
    rows[4] = '{8'hab, 3'h3, 4'h3, 1'b1, 1'b0, DEV, DEV, 1'b0};
    rows[5] = '{8'hb9, 3'h0, 4'h0, 1'b0, 1'b0, MFR, DEV, 1'b1};
    rows[6] = '{8'hab, 3'h0, 4'h0, 1'b0, 1'b0, MFR, DEV, 1'b0};
    rows[7] = '{8'hab, 3'h3, 4'h2, 1'b0, 1'b0, DEV, DEV, 1'b0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk1("asleep after reset", 1'b0, asleep);
    foreach (rows[j])
      host_cmd(rows[j]);
    $display("test table done");
    foreach (SEQ_OP[j])
    begin
      frame_b(SEQ_OP[j], SEQ_N[j]);
      chk1("asleep_b", SEQ_X[j], asleep_b);
    end
    $display("test sleep framing done");
    lk_b.cs_n <= 1'b0;
    shift_b(8'h90, 8);
    repeat (3) shift_b(8'h00, 8);
    shift_b(8'h00, 5);
    lk_b.pause_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk1("paused_b", 1'b1, paused_b);
    chk1("so_oe_n paused", 1'b1, lk_b.so_oe_n);
    lk_b.wp_n <= 1'b0;
    shift_b(8'hff, 3);
    chk1("wp_b", 1'b0, wp_b);
    lk_b.pause_n <= 1'b1;
    lk_b.wp_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk1("paused_b released", 1'b0, paused_b);
    shift_b(8'h00, 3);
    chk8("rx_b across pause", {MFR[4:3], 3'h7, MFR[2:0]}, rx_b);
    shift_b(8'h00, 3);
    lk_b.cs_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk1("so_oe_n released", 1'b1, lk_b.so_oe_n);
    $display("test pause done");
    set_b <= 1'b1;
    @(posedge clk);
    set_b <= 1'b0;
    repeat (8) @(posedge clk);
    chk1("flag_b set", 1'b1, flag_b);
    lk_b.cs_n <= 1'b0;
    half();
    lk_b.sck <= 1'b1;
    lk_b.pause_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk1("paused_b clock high", 1'b0, paused_b);
    lk_b.sck <= 1'b0;
    repeat (6) @(posedge clk);
    chk1("paused_b clock low", 1'b1, paused_b);
    lk_b.cs_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk1("flag_b cleared", 1'b0, flag_b);
    chk1("paused_b deselected", 1'b0, paused_b);
    lk_b.pause_n <= 1'b1;
    quad_b <= 1'b1;
    lk_b.cs_n <= 1'b0;
    repeat (2) @(posedge clk);
    lk_b.pause_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk1("paused_b quad", 1'b0, paused_b);
    lk_b.cs_n <= 1'b1;
    lk_b.pause_n <= 1'b1;
    repeat (8) @(posedge clk);
    quad_b <= 1'b0;
    $display("test abort and quad done");
    frame_b(8'hb9, 8);
    chk1("asleep_b before reset", 1'b1, asleep_b);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk1("asleep_b after reset", 1'b0, asleep_b);
    $display("test reset done");
    wrap_up();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule
